//--- rtl/core_map.svh
// Purpose: Offsets, field positions, reset values and counts for the core
// Assumes: Included by its bare name from every design file that needs it
// Notes: Definitions only
`ifndef CORE_MAP_SVH
`define CORE_MAP_SVH

// =====================================================================
// Register offsets (byte addresses)
`define INSTR_OFS 12'h000
`define STATUS_OFS 12'h004
`define ACC_OFS 12'h008
`define PC_OFS 12'h00C
`define GUARD_OFS 12'h010
`define STACK_OFS 12'h014
`define WAKE_OFS 12'h018
`define FILE_REGION 3'h1

// =====================================================================
// Command word fields
`define INSTR_OP_MSB 19
`define INSTR_OP_LSB 16
`define INSTR_TSEL_BIT 15
`define INSTR_IDX_MSB 14
`define INSTR_IDX_LSB 8
`define INSTR_IMM_MSB 7
`define INSTR_IMM_LSB 0

// =====================================================================
// Status bit positions
`define ST_CARRY 0
`define ST_NIBBLE 1
`define ST_NULL 2
`define ST_PWRDN 3
`define ST_EXPIRY 4
`define ST_IRQ_ALLOW 5
`define ST_SLEEP 6
`define ST_BUSY 7

// =====================================================================
// Reset values and counts
`define ACC_RST 8'h00
`define PC_RST 13'h0000
`define PWRDN_RST 1'h1
`define EXPIRY_RST 1'h1
`define IRQ_ALLOW_RST 1'h0
`define GUARD_CLR 8'h00
`define ONE_CYCLE_BUSY 1'h0
`define TWO_CYCLE_BUSY 1'h1
`define FILE_DEPTH 128
`define STACK_DEPTH 8

`endif

//--- rtl/core_pkg.sv
// Purpose: Types shared by the core files
// Assumes: Nothing beyond the language
// Notes: Operation codes follow declaration order starting at zero
package core_pkg;

    typedef enum logic [3:0] {
        idle_op,
        register_move_op,
        load_literal_op,
        store_accumulator_op,
        interrupt_return_op,
        literal_return_op,
        rotate_left_op,
        power_down_op,
        subroutine_return_op,
        literal_minus_acc_op
    } op_t;

    typedef logic [7:0] byte_t;
    typedef logic [12:0] addr_t;

endpackage

//--- rtl/cpu_move_return_sleep_ops.sv
// Purpose: Execute move, return, rotate, power-down and subtract operations
// Assumes: APB master; one command word executes per INSTR write made outside the low-power state
// Notes: Two-cycle operations set busy for the one cycle that pready is high, so no INSTR write stalls
//
// Function
// - Register move copies file entry to accumulator or back to itself.
// - Register move sets result_null_flag from the moved value.
// - Load literal puts immediate into accumulator, flags untouched.
// - Interrupt return loads PC from stack head and sets global_irq_allow.
// - Store accumulator writes accumulator to file entry, flags untouched.
// - Literal return loads accumulator with the immediate byte.
// - Literal return reloads PC from stack head, takes two cycles.
// - Rotate left through bit_out_flag into accumulator or file entry.
// - Power-down clears power_down_bit.
// - Power-down sets timer_expiry_bit.
// - Power-down clears guard_timer count and its prescaler.
// - Power-down enters low-power state with oscillator halted.
// - Subroutine return pops stack into PC, takes two cycles.
// - Literal minus accumulator into accumulator, updating three flags.
//
// Added by the designer: the APB register port and the register addresses.
`include "core_map.svh"
module cpu_move_return_sleep_ops
    import core_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic osc_run,
    output logic low_power
);

    // =================================================================
    // State
    byte_t acc_ff, nxt_acc;
    addr_t pc_ff, nxt_pc;
    logic carry_ff, nxt_carry;
    logic nibble_ff, nxt_nibble;
    logic null_ff, nxt_null;
    logic pwrdn_ff, nxt_pwrdn;
    logic expiry_ff, nxt_expiry;
    logic irq_allow_ff, nxt_irq_allow;
    logic sleep_ff, nxt_sleep;
    logic osc_ff, nxt_osc;
    logic busy_ff, nxt_busy;
    byte_t guard_cnt_ff, nxt_guard_cnt;
    byte_t guard_pre_ff, nxt_guard_pre;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;

    // =================================================================
    // Bus decode
    logic access;
    logic wr;
    logic hit_instr;
    logic hit_file;
    logic mapped;
    logic stall;
    logic exec;
    op_t op;
    logic tsel;
    logic [6:0] idx;
    byte_t imm;

    assign access = psel & penable & ~pready_ff;
    assign wr = access & pwrite;
    assign hit_instr = (paddr == `INSTR_OFS);
    assign hit_file = (paddr[11:9] == `FILE_REGION);
    assign mapped = hit_instr | hit_file | (paddr == `STATUS_OFS)
        | (paddr == `ACC_OFS) | (paddr == `PC_OFS)
        | (paddr == `GUARD_OFS) | (paddr == `STACK_OFS)
        | (paddr == `WAKE_OFS);
    assign stall = hit_instr & pwrite & busy_ff;
    assign exec = wr & hit_instr & ~busy_ff & ~sleep_ff;
    assign op = op_t'(pwdata[`INSTR_OP_MSB:`INSTR_OP_LSB]);
    assign tsel = pwdata[`INSTR_TSEL_BIT];
    assign idx = pwdata[`INSTR_IDX_MSB:`INSTR_IDX_LSB];
    assign imm = pwdata[`INSTR_IMM_MSB:`INSTR_IMM_LSB];

    // =================================================================
    // File registers and return stack
    logic fr_we;
    logic [6:0] fr_widx;
    byte_t fr_wdata;
    byte_t fr_op;
    byte_t fr_bus;
    logic stk_push;
    logic stk_pop;
    addr_t stk_head;

    file_regs u_file_regs (
        .pclk(pclk),
        .presetn(presetn),
        .we(fr_we),
        .widx(fr_widx),
        .wdata(fr_wdata),
        .ridx_a(idx),
        .rdata_a(fr_op),
        .ridx_b(paddr[8:2]),
        .rdata_b(fr_bus)
    );

    return_stack u_return_stack (
        .pclk(pclk),
        .presetn(presetn),
        .push(stk_push),
        .pop(stk_pop),
        .push_data(pwdata[12:0]),
        .head(stk_head)
    );

    // =================================================================
    // Arithmetic
    logic [8:0] diff;
    logic [4:0] diff_lo;
    byte_t rot;

    assign diff = {1'h0, imm} + {1'h0, ~acc_ff} + 9'h001;
    assign diff_lo = {1'h0, imm[3:0]} + {1'h0, ~acc_ff[3:0]} + 5'h01;
    assign rot = {fr_op[6:0], carry_ff};

    // =================================================================
    // Core next state
    always_comb begin
        nxt_acc = acc_ff;
        nxt_pc = pc_ff;
        nxt_carry = carry_ff;
        nxt_nibble = nibble_ff;
        nxt_null = null_ff;
        nxt_pwrdn = pwrdn_ff;
        nxt_expiry = expiry_ff;
        nxt_irq_allow = irq_allow_ff;
        nxt_sleep = sleep_ff;
        nxt_busy = `ONE_CYCLE_BUSY;
        nxt_guard_cnt = guard_cnt_ff;
        nxt_guard_pre = guard_pre_ff;
        fr_we = 1'h0;
        fr_widx = idx;
        fr_wdata = fr_op;
        stk_push = 1'h0;
        stk_pop = 1'h0;
        if (!sleep_ff) begin
            nxt_guard_pre = guard_pre_ff + 8'h01;
            if (guard_pre_ff == 8'hFF) begin
                nxt_guard_cnt = guard_cnt_ff + 8'h01;
            end
        end
        if (exec) begin
            nxt_pc = pc_ff + 13'h0001;
            case (op)
                register_move_op: begin
                    nxt_null = (fr_op == 8'h00);
                    if (tsel) begin
                        fr_we = 1'h1;
                    end else begin
                        nxt_acc = fr_op;
                    end
                end
                load_literal_op: begin
                    nxt_acc = imm;
                end
                store_accumulator_op: begin
                    fr_we = 1'h1;
                    fr_wdata = acc_ff;
                end
                interrupt_return_op: begin
                    nxt_pc = stk_head;
                    nxt_irq_allow = 1'h1;
                    stk_pop = 1'h1;
                    nxt_busy = `TWO_CYCLE_BUSY;
                end
                literal_return_op: begin
                    nxt_acc = imm;
                    nxt_pc = stk_head;
                    stk_pop = 1'h1;
                    nxt_busy = `TWO_CYCLE_BUSY;
                end
                rotate_left_op: begin
                    nxt_carry = fr_op[7];
                    if (tsel) begin
                        fr_we = 1'h1;
                        fr_wdata = rot;
                    end else begin
                        nxt_acc = rot;
                    end
                end
                power_down_op: begin
                    nxt_pwrdn = 1'h0;
                    nxt_expiry = 1'h1;
                    nxt_guard_cnt = `GUARD_CLR;
                    nxt_guard_pre = `GUARD_CLR;
                    nxt_sleep = 1'h1;
                end
                subroutine_return_op: begin
                    stk_pop = 1'h1;
                    nxt_pc = stk_head;
                    nxt_busy = `TWO_CYCLE_BUSY;
                end
                literal_minus_acc_op: begin
                    nxt_acc = diff[7:0];
                    nxt_carry = diff[8];
                    nxt_nibble = diff_lo[4];
                    nxt_null = (diff[7:0] == 8'h00);
                end
                default: begin
                    nxt_pc = pc_ff + 13'h0001;
                end
            endcase
        end else if (wr) begin
            if (hit_file) begin
                fr_we = 1'h1;
                fr_widx = paddr[8:2];
                fr_wdata = pwdata[7:0];
            end
            case (paddr)
                `STATUS_OFS: begin
                    nxt_carry = pwdata[`ST_CARRY];
                    nxt_nibble = pwdata[`ST_NIBBLE];
                    nxt_null = pwdata[`ST_NULL];
                    nxt_irq_allow = pwdata[`ST_IRQ_ALLOW];
                end
                `ACC_OFS: nxt_acc = pwdata[7:0];
                `PC_OFS: nxt_pc = pwdata[12:0];
                `GUARD_OFS: begin
                    nxt_guard_cnt = `GUARD_CLR;
                    nxt_guard_pre = `GUARD_CLR;
                end
                `STACK_OFS: stk_push = 1'h1;
                `WAKE_OFS: begin
                    if (pwdata[0]) begin
                        nxt_sleep = 1'h0;
                    end
                end
                default: begin
                end
            endcase
        end
        nxt_osc = ~nxt_sleep;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_ff <= `ACC_RST;
            pc_ff <= `PC_RST;
            carry_ff <= 1'h0;
            nibble_ff <= 1'h0;
            null_ff <= 1'h0;
            pwrdn_ff <= `PWRDN_RST;
            expiry_ff <= `EXPIRY_RST;
            irq_allow_ff <= `IRQ_ALLOW_RST;
            sleep_ff <= 1'h0;
            osc_ff <= 1'h1;
            busy_ff <= `ONE_CYCLE_BUSY;
            guard_cnt_ff <= `GUARD_CLR;
            guard_pre_ff <= `GUARD_CLR;
        end else begin
            acc_ff <= nxt_acc;
            pc_ff <= nxt_pc;
            carry_ff <= nxt_carry;
            nibble_ff <= nxt_nibble;
            null_ff <= nxt_null;
            pwrdn_ff <= nxt_pwrdn;
            expiry_ff <= nxt_expiry;
            irq_allow_ff <= nxt_irq_allow;
            sleep_ff <= nxt_sleep;
            osc_ff <= nxt_osc;
            busy_ff <= nxt_busy;
            guard_cnt_ff <= nxt_guard_cnt;
            guard_pre_ff <= nxt_guard_pre;
        end
    end

    // =================================================================
    // Bus answer
    always_comb begin
        nxt_pready = 1'h0;
        nxt_pslverr = 1'h0;
        nxt_prdata = 32'h00000000;
        if (access && !stall) begin
            nxt_pready = 1'h1;
            nxt_pslverr = ~mapped | (hit_instr & pwrite & sleep_ff);
            if (!pwrite) begin
                if (hit_file) begin
                    nxt_prdata = {24'h000000, fr_bus};
                end
                case (paddr)
                    `STATUS_OFS: nxt_prdata = {24'h000000, busy_ff,
                        sleep_ff, irq_allow_ff, expiry_ff, pwrdn_ff, null_ff,
                        nibble_ff, carry_ff};
                    `ACC_OFS: nxt_prdata = {24'h000000, acc_ff};
                    `PC_OFS: nxt_prdata = {19'h00000, pc_ff};
                    `GUARD_OFS: nxt_prdata = {16'h0000, guard_pre_ff,
                        guard_cnt_ff};
                    `STACK_OFS: nxt_prdata = {19'h00000, stk_head};
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'h0;
            pslverr_ff <= 1'h0;
        end else begin
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign osc_run = osc_ff;
    assign low_power = sleep_ff;

endmodule

//--- rtl/file_regs.sv
// Purpose: 128-entry file register array with one write and two read ports
// Assumes: One write per clock at most
// Notes: Reads are combinational by index
`include "core_map.svh"
module file_regs
    import core_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic we,
    input wire logic [6:0] widx,
    input wire byte_t wdata,
    input wire logic [6:0] ridx_a,
    output byte_t rdata_a,
    input wire logic [6:0] ridx_b,
    output byte_t rdata_b
);

    byte_t mem_ff [`FILE_DEPTH];

    // =================================================================
    // Storage
    genvar i;
    generate
        for (i = 0; i < `FILE_DEPTH; i++) begin : g_entry
            byte_t nxt_mem;
            always_comb begin
                nxt_mem = mem_ff[i];
                if (we && widx == 7'(i)) begin
                    nxt_mem = wdata;
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    mem_ff[i] <= 8'h00;
                end else begin
                    mem_ff[i] <= nxt_mem;
                end
            end
        end
    endgenerate

    assign rdata_a = mem_ff[ridx_a];
    assign rdata_b = mem_ff[ridx_b];

endmodule

//--- rtl/return_stack.sv
// Purpose: Circular return-address stack
// Assumes: Push and pop never in the same cycle
// Notes: Overflow wraps and overwrites the oldest entry
`include "core_map.svh"
module return_stack
    import core_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic push,
    input wire logic pop,
    input wire addr_t push_data,
    output addr_t head
);

    addr_t entry_ff [`STACK_DEPTH];
    logic [2:0] ptr_ff;
    logic [2:0] nxt_ptr;

    // =================================================================
    // Pointer
    always_comb begin
        nxt_ptr = ptr_ff;
        if (push) begin
            nxt_ptr = ptr_ff + 3'h1;
        end else if (pop) begin
            nxt_ptr = ptr_ff - 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_ff <= 3'h0;
        end else begin
            ptr_ff <= nxt_ptr;
        end
    end

    // =================================================================
    // Entries
    genvar i;
    generate
        for (i = 0; i < `STACK_DEPTH; i++) begin : g_slot
            addr_t nxt_entry;
            always_comb begin
                nxt_entry = entry_ff[i];
                if (push && ptr_ff == 3'(i)) begin
                    nxt_entry = push_data;
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    entry_ff[i] <= 13'h0000;
                end else begin
                    entry_ff[i] <= nxt_entry;
                end
            end
        end
    endgenerate

    assign head = entry_ff[ptr_ff - 3'h1];

endmodule

//--- tb/cpu_move_return_sleep_ops_tb.sv
// Purpose: Self-checking bench for the move, return and sleep core
// Assumes: APB master with one idle cycle between transfers
// Notes: Random operands from a fixed seed plus corner values
`include "core_map.svh"
module cpu_move_return_sleep_ops_tb
    import core_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, osc_run, low_power;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    integer seed = 32'h8A38;
    logic [31:0] r, rnd;
    logic e, t;
    logic [7:0] a, k, v, x;
    logic [6:0] ix;
    logic [2:0] f;
    logic [3:0] oc;
    logic [12:0] ra;
    logic [10:0] s;

    always #5 pclk = ~pclk;

    cpu_move_return_sleep_ops dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .osc_run, .low_power);

    // =================================================================
    // Reporting
    task automatic end_sim();
        if (bad_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] y);
        checks++;
        if (g !== y) begin
            bad_count++;
            $display("BAD %0t got %h exp %h", $time, g, y);
        end
    endtask

    // =================================================================
    // Bus cycles
    task automatic xfer(input logic w, input logic [11:0] ad,
                        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        xfer(1'b1, ad, d);
        chk({31'h0, e}, 32'h0);
    endtask

    task automatic rd(input logic [11:0] ad, input logic [31:0] y);
        xfer(1'b0, ad, 32'h0);
        chk({31'h0, e}, 32'h0);
        chk(r, y);
    endtask

    task automatic op(input logic [3:0] c, input logic tt,
                      input logic [6:0] i, input logic [7:0] kk);
        wr(`INSTR_OFS, {12'h000, c, tt, i, kk});
    endtask

    function automatic logic [11:0] fa(input logic [6:0] i);
        fa = 12'h200 + {3'h0, i, 2'h0};
    endfunction

    // Returns zero, nibble and carry flags above the difference
    function automatic logic [10:0] sub_f(input logic [7:0] kk,
                                          input logic [7:0] w);
        logic [7:0] d;
        d = kk - w;
        sub_f = {d == 8'h00, kk[3:0] >= w[3:0], kk >= w, d};
    endfunction

    // =================================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(`STATUS_OFS, 32'h18);
        rd(`PC_OFS, 32'h0);
        for (int i = 0; i < 24; i++) begin
            rnd = $random(seed);
            a = rnd[7:0];
            k = rnd[15:8];
            v = rnd[23:16];
            ix = rnd[30:24];
            t = rnd[31];
            rnd = $random(seed);
            f = rnd[2:0];
            ra = rnd[15:3];
            if (i == 0)
                k = a;
            if (i == 1) begin
                a = 8'h00;
                k = 8'h01;
            end
            if (i == 2)
                v = 8'h00;
            wr(`STATUS_OFS, {29'h0, f});
            wr(`ACC_OFS, {24'h0, a});
            op(load_literal_op, 1'b0, 7'h00, k);
            rd(`ACC_OFS, {24'h0, k});
            rd(`STATUS_OFS, {29'h3, f});
            op(store_accumulator_op, 1'b0, ix, 8'h00);
            rd(fa(ix), {24'h0, k});
            rd(`STATUS_OFS, {29'h3, f});
            op(literal_minus_acc_op, 1'b0, 7'h00, a);
            s = sub_f(a, k);
            rd(`ACC_OFS, {24'h0, s[7:0]});
            rd(`STATUS_OFS, {29'h3, s[10:8]});
            wr(`STATUS_OFS, {29'h0, f});
            op(rotate_left_op, t, ix, 8'h00);
            x = {k[6:0], f[0]};
            rd(fa(ix), {24'h0, t ? x : k});
            rd(`ACC_OFS, {24'h0, t ? s[7:0] : x});
            rd(`STATUS_OFS, {29'h3, f[2:1], k[7]});
            wr(fa(ix), {24'h0, v});
            wr(`ACC_OFS, {24'h0, a});
            wr(`STATUS_OFS, {29'h0, f});
            op(register_move_op, t, ix, 8'h00);
            rd(`ACC_OFS, {24'h0, t ? a : v});
            rd(fa(ix), {24'h0, v});
            rd(`STATUS_OFS, {29'h3, v == 8'h00, f[1:0]});
            oc = 4'h9 + 4'(i % 7);
            if (i % 7 == 0)
                oc = idle_op;
            wr(`PC_OFS, {19'h0, ra});
            op(oc, t, ix, k);
            rd(`PC_OFS, {19'h0, ra + 13'h1});
            rd(`ACC_OFS, {24'h0, t ? a : v});
            rd(`STATUS_OFS, {29'h3, v == 8'h00, f[1:0]});
            oc = (i % 3 == 0) ? interrupt_return_op :
                 (i % 3 == 1) ? literal_return_op : subroutine_return_op;
            wr(`STACK_OFS, {19'h0, ra});
            wr(`STATUS_OFS, 32'h0);
            op(oc, 1'b0, 7'h00, k);
            op(idle_op, 1'b0, 7'h00, 8'h00);
            rd(`PC_OFS, {19'h0, ra + 13'h1});
            rd(`STACK_OFS, 32'h0);
            rd(`STATUS_OFS, (i % 3 == 0) ? 32'h38 : 32'h18);
            rd(`ACC_OFS, {24'h0, (i % 3 == 1) ? k : (t ? a : v)});
        end
        wr(`ACC_OFS, 32'h0);
        wr(`STATUS_OFS, 32'h0);
        op(power_down_op, 1'b0, 7'h00, 8'h00);
        chk({30'h0, low_power, osc_run}, 32'h2);
        rd(`STATUS_OFS, 32'h50);
        rd(`GUARD_OFS, 32'h0);
        xfer(1'b1, `INSTR_OFS, {12'h000, 4'h2, 16'h0055});
        chk({31'h0, e}, 32'h1);
        rd(`ACC_OFS, 32'h0);
        wr(`WAKE_OFS, 32'h1);
        rd(`STATUS_OFS, 32'h10);
        chk({30'h0, low_power, osc_run}, 32'h1);
        xfer(1'b0, 12'h01C, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        xfer(1'b1, 12'h400, 32'hFFFF_FFFF);
        chk({31'h0, e}, 32'h1);
        end_sim();
    end
endmodule

//--- tb/cpu_ops_assertions.sv
// Purpose: Bus handshake and power-state checks at the core's ports
// Assumes: Sees only the ports of the top module
// Notes: Bound to the core at the foot of this file
module cpu_ops_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic osc_run,
    input wire logic low_power
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic unmapped;
    assign unmapped = (paddr > 12'h018 && paddr < 12'h200) || paddr > 12'h3FF;

    // =================================================================
    // Transfer phases
    sequence wait_acc;
        psel && penable && !pready;
    endsequence
    sequence instr_asleep;
        psel && penable && !pready && pwrite && paddr == 12'h000 && low_power;
    endsequence
    sequence sleep_done;
        psel && penable && pready && pwrite && paddr == 12'h000 &&
            pwdata[19:16] == 4'h7 && !pslverr;
    endsequence

    // =================================================================
    // Properties
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_READY_BOUND: assert property (wait_acc |-> ##[1:2] pready)
        else $error("no pready within two cycles");
    AST_ERR_QUAL: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero outside pready");
    AST_OSC_HALT: assert property (low_power |-> !osc_run)
        else $error("oscillator runs in low power");
    AST_SLEEP_ENTER: assert property
        (sleep_done |=> low_power && !osc_run)
        else $error("power-down did not halt the core");
    AST_ASLEEP_REFUSE: assert property
        (instr_asleep |-> ##[1:2] (pready && pslverr))
        else $error("command accepted while asleep");
    AST_UNMAPPED: assert property (wait_acc ##0 unmapped |->
            ##[1:2] (pready && pslverr && prdata == 32'h0000_0000))
        else $error("unmapped access not refused");
endmodule

bind cpu_move_return_sleep_ops cpu_ops_checker chk_u (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .osc_run,
    .low_power);
